// *** src/sio_port_map.svh ***
// register offsets, field positions, reset values and pin positions
`ifndef SIO_PORT_MAP_SVH
`define SIO_PORT_MAP_SVH

// register offsets on the plain register port (4-bit address)
`define SIO_OFF_DATA     4'h0
`define SIO_OFF_DIR      4'h1
`define SIO_OFF_SEGSEL   4'h2
`define SIO_OFF_CTRL     4'h3
`define SIO_OFF_LEVEL    4'h4

// reset values
`define SIO_DATA_RST     8'h00
`define SIO_DIR_RST      8'h00
`define SIO_SEGSEL_RST   8'h00
`define SIO_CTRL_RST     8'h00
`define SIO_RDATA_RST    8'h00
`define SIO_UNMAPPED_RD  8'h00

// control register fields
`define SIO_CTRL_LCD_PORT_INPUT_CONTROL   0
`define SIO_CTRL_SPL     1
`define SIO_CTRL_MASK    8'h03

// pin positions of the timer channel 1 functions
`define SIO_TMR_A_PIN    6
`define SIO_TMR_B_PIN    5
`define SIO_EXTCLK_PIN   7

// first lcd segment carried by pin 0
`define SIO_SEG_BASE     14

`endif

// *** src/sio_pkg.sv ***
// types shared by the shared io port and its pin multiplexer
package sio_pkg;

  typedef logic [7:0] sio_byte_t;   // one byte of register or pins
  typedef logic [3:0] sio_addr_t;   // register port address

  // who owns a pin; gray along port -> timer -> lcd -> forced hi-z
  typedef enum logic [1:0] {
    SIO_OWN_PORT  = 2'b00,
    SIO_OWN_TIMER = 2'b01,
    SIO_OWN_LCD   = 2'b11,
    SIO_OWN_HIZ   = 2'b10
  } sio_owner_e;

endpackage

// *** src/sio_pin_mux.sv ***
// one pin of the shared port: driver selection and input gating
`timescale 1ns/1ps
`default_nettype none

module sio_pin_mux
  import sio_pkg::*;
(
  input  wire logic        latch_in,      // data latch bit
  input  wire logic        dir_in,        // 1 = output
  input  wire logic        seg_sel_in,    // lcd segment selected
  input  wire logic        lcd_port_input_control_in,      // lcd port input control
  input  wire logic        hiz_in,        // standby forced hi-z
  input  wire logic        periph_oe_in,  // timer output enable
  input  wire logic        periph_val_in, // timer output value
  input  wire logic        lcd_val_in,    // lcd segment level
  input  wire logic        pin_in,        // pad input level
  output logic             pin_out,       // pad output value
  output logic             pin_oe_out,    // pad driven when high
  output logic             level_out,     // gated internal level
  output sio_pkg::sio_owner_e owner_out   // current pin owner
);

  //////////////////////////////////////////////////////////////////////
  // ownership: hi-z force beats lcd, lcd beats timer, timer beats port
  wire logic lcd_own;   // segment drives the pin
  wire logic port_drv;  // port latch drives the pin

  assign lcd_own  = seg_sel_in & lcd_port_input_control_in;
  // port driver stays off until the lcd mux hands the pin over
  assign port_drv = dir_in & lcd_port_input_control_in & ~seg_sel_in;

  assign owner_out = hiz_in       ? SIO_OWN_HIZ   :
                     lcd_own      ? SIO_OWN_LCD   :
                     periph_oe_in ? SIO_OWN_TIMER :
                                    SIO_OWN_PORT;

  //////////////////////////////////////////////////////////////////////
  // pad driver
  assign pin_oe_out = (owner_out == SIO_OWN_LCD)   |
                      (owner_out == SIO_OWN_TIMER) |
                      ((owner_out == SIO_OWN_PORT) & port_drv);
  assign pin_out    = (owner_out == SIO_OWN_LCD)   ? lcd_val_in    :
                      (owner_out == SIO_OWN_TIMER) ? periph_val_in :
                      (owner_out == SIO_OWN_PORT)  ? latch_in      :
                                                     1'b0;

  // input cut off and held low while forced hi-z, avoids a floating leak
  assign level_out = pin_in & ~hiz_in;

endmodule

`default_nettype wire

// *** src/sio_port_e.sv ***
// eight-pin shared general-purpose io port with register access
`timescale 1ns/1ps
`default_nettype none
`include "sio_port_map.svh"

//////////////////////////////////////////////////////////////////////////
// Overview of operation
// - eight pins, pin n is register bit n
// - direction one drives latch onto pin
// - direction zero turns pin driver off
// - data write always updates latch
// - output pin reads back latch bit
// - input pin reads level, rmw reads latch
// - peripheral output enable overrides port latch
// - peripheral pin reads level, rmw latch
// - peripheral input: direction zero, level read
// - port use: segment off, input control on
// - pins carry segments 14-21 and timer
// - reset clears direction, pins hi-z
// - standby with select forces hi-z, input low
// - standby without select keeps pins unchanged
module sio_port_e
  import sio_pkg::*;
(
  input  wire logic            clk_in,          // cpu clock
  input  wire logic            rst_in,          // cpu reset, async high
  input  wire sio_pkg::sio_addr_t reg_addr_in,  // register address
  input  wire sio_pkg::sio_byte_t reg_wdata_in, // write data
  input  wire logic            reg_wr_in,       // write strobe
  input  wire logic            reg_rd_in,       // read strobe
  input  wire logic            reg_rmw_in,      // read is read-modify-write
  output sio_pkg::sio_byte_t   reg_rdata_out,   // read data, next cycle
  input  wire sio_pkg::sio_byte_t pin_in,       // pad levels
  output sio_pkg::sio_byte_t   pin_out,         // pad output values
  output sio_pkg::sio_byte_t   pin_oe_out,      // pad drive enables
  input  wire sio_pkg::sio_byte_t lcd_seg_in,   // segments 14..21
  input  wire logic            tmr_out_a_in,    // timer1 output a
  input  wire logic            tmr_oe_a_in,     // its output enable
  input  wire logic            tmr_out_b_in,    // timer1 output b
  input  wire logic            tmr_oe_b_in,     // its output enable
  output logic                 tmr_ext_clk_out, // timer1 external clock
  input  wire logic            standby_stop_in  // stop or watch mode
);

  import sio_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // address match, used by both the write and the read decode
  function automatic logic addr_hit(input sio_addr_t a,
                                    input sio_addr_t off);
    addr_hit = (a == off);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // registers
  sio_byte_t port_e_data_latch; // output latch, one bit per pin
  sio_byte_t port_e_direction;  // 1 = output
  sio_byte_t lcd_segment_sel;   // segment select, reset clears all eight select bits
  logic      lcd_port_input_control; // lcd pin mux handed over
  logic      standby_pin_hiz_select; // force hi-z in stop or watch

  // control reset value as a byte, so its bits can be picked apart
  localparam sio_byte_t ctrl_rst_val = `SIO_CTRL_RST;

  // per-pin views
  sio_byte_t  level;        // gated internal pin level
  sio_byte_t  periph_oe;    // timer output enables by pin
  sio_byte_t  periph_val;   // timer output values by pin
  sio_owner_e owner [8];    // pin owner from each mux
  sio_byte_t  latch_rd;     // bits whose ordinary read is the latch
  sio_byte_t  data_rd;      // read value of the data register, the latch on rmw
  sio_byte_t  next_rdata;   // read data for the next cycle
  wire logic  hiz_force;    // standby forcing all pins hi-z

  //////////////////////////////////////////////////////////////////////
  // address decode
  wire logic wr_data  = reg_wr_in & addr_hit(reg_addr_in, `SIO_OFF_DATA);
  wire logic wr_dir   = reg_wr_in & addr_hit(reg_addr_in, `SIO_OFF_DIR);
  wire logic wr_seg   = reg_wr_in & addr_hit(reg_addr_in, `SIO_OFF_SEGSEL);
  wire logic wr_ctrl  = reg_wr_in & addr_hit(reg_addr_in, `SIO_OFF_CTRL);

  // stop and watch only; sleep leaves the port running
  assign hiz_force = standby_stop_in & standby_pin_hiz_select;

  //////////////////////////////////////////////////////////////////////
  // data latch: written whatever the direction
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_e_data_latch <= `SIO_DATA_RST;
    end else if (wr_data) begin
      port_e_data_latch <= reg_wdata_in;
    end
  end

  // direction: cleared by reset, pins then come up as inputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_e_direction <= `SIO_DIR_RST;
    end else if (wr_dir) begin
      port_e_direction <= reg_wdata_in;
    end
  end

  // lcd segment select; a set bit hands the pin to the segment
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lcd_segment_sel <= `SIO_SEGSEL_RST;
    end else if (wr_seg) begin
      lcd_segment_sel <= reg_wdata_in;
    end
  end

  // control bits; port stays non-functional until input control is set
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lcd_port_input_control <= ctrl_rst_val[`SIO_CTRL_LCD_PORT_INPUT_CONTROL];
      standby_pin_hiz_select <= ctrl_rst_val[`SIO_CTRL_SPL];
    end else if (wr_ctrl) begin
      lcd_port_input_control <= reg_wdata_in[`SIO_CTRL_LCD_PORT_INPUT_CONTROL];
      standby_pin_hiz_select <= reg_wdata_in[`SIO_CTRL_SPL];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // timer channel 1 outputs placed on their pins
  always_comb begin
    periph_oe  = 8'h00;
    periph_val = 8'h00;
    periph_oe[`SIO_TMR_A_PIN]  = tmr_oe_a_in;
    periph_val[`SIO_TMR_A_PIN] = tmr_out_a_in;
    periph_oe[`SIO_TMR_B_PIN]  = tmr_oe_b_in;
    periph_val[`SIO_TMR_B_PIN] = tmr_out_b_in;
  end

  //////////////////////////////////////////////////////////////////////
  // one multiplexer per pin, pin n on bit n
  for (genvar n = 0; n < 8; n++) begin : g_pin
    sio_pin_mux u_mux (
      .latch_in      (port_e_data_latch[n]),
      .dir_in        (port_e_direction[n]),
      .seg_sel_in    (lcd_segment_sel[n]),
      .lcd_port_input_control_in      (lcd_port_input_control),
      .hiz_in        (hiz_force),
      .periph_oe_in  (periph_oe[n]),
      .periph_val_in (periph_val[n]),
      .lcd_val_in    (lcd_seg_in[n]),
      .pin_in        (pin_in[n]),
      .pin_out       (pin_out[n]),
      .pin_oe_out    (pin_oe_out[n]),
      .level_out     (level[n]),
      .owner_out     (owner[n])
    );
    // latch read only where the port itself drives the pin
    assign latch_rd[n] = (owner[n] == SIO_OWN_PORT) &
                         port_e_direction[n] & ~lcd_segment_sel[n] &
                         lcd_port_input_control;
  end

  // timer external clock sees the level, whatever the direction
  assign tmr_ext_clk_out = level[`SIO_EXTCLK_PIN];

  //////////////////////////////////////////////////////////////////////
  // read paths: rmw takes the latch so a bit-set keeps other outputs
  assign data_rd = reg_rmw_in ? port_e_data_latch :
                   (port_e_data_latch & latch_rd) |
                   (level & ~latch_rd);

  always_comb begin
    if (addr_hit(reg_addr_in, `SIO_OFF_DATA)) begin
      next_rdata = data_rd;
    end else if (addr_hit(reg_addr_in, `SIO_OFF_DIR)) begin
      next_rdata = port_e_direction;
    end else if (addr_hit(reg_addr_in, `SIO_OFF_SEGSEL)) begin
      next_rdata = lcd_segment_sel;
    end else if (addr_hit(reg_addr_in, `SIO_OFF_CTRL)) begin
      next_rdata = 8'h00;
      next_rdata[`SIO_CTRL_LCD_PORT_INPUT_CONTROL] = lcd_port_input_control;
      next_rdata[`SIO_CTRL_SPL]   = standby_pin_hiz_select;
    end else if (addr_hit(reg_addr_in, `SIO_OFF_LEVEL)) begin
      next_rdata = level;
    end else begin
      next_rdata = `SIO_UNMAPPED_RD;
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= `SIO_RDATA_RST;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end else begin
      reg_rdata_out <= `SIO_RDATA_RST;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // assertion helpers
  sio_byte_t port_mask;  // pins driven by the port latch
  sio_byte_t off_mask;   // pins nobody may drive
  sio_byte_t tmr_mask;   // pins driven by the timer
  sio_byte_t lcd_mask;   // pins driven by lcd segments
  assign port_mask = port_e_direction & ~lcd_segment_sel & ~periph_oe &
                     {8{lcd_port_input_control & ~hiz_force}};
  assign off_mask  = ~port_e_direction & ~periph_oe &
                     ~(lcd_segment_sel & {8{lcd_port_input_control}});
  assign tmr_mask  = periph_oe & ~(lcd_segment_sel &
                     {8{lcd_port_input_control}}) & {8{~hiz_force}};
  assign lcd_mask  = lcd_segment_sel &
                     {8{lcd_port_input_control & ~hiz_force}};

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_rd_plain;
    reg_rd_in && !reg_rmw_in && reg_addr_in == `SIO_OFF_DATA;
  endsequence
  sequence s_rd_rmw;
    reg_rd_in && reg_rmw_in && reg_addr_in == `SIO_OFF_DATA;
  endsequence
  sequence s_wr_dir_then_rd;
    wr_dir ##1 reg_rd_in && reg_addr_in == `SIO_OFF_DIR;
  endsequence
  // stop mode without hi-z select and no register write this cycle
  sequence s_standby_quiet;
    standby_stop_in && !standby_pin_hiz_select && !reg_wr_in;
  endsequence

  //////////////////////////////////////////////////////////////////////
  // assertions
  out_drive_a: assert property (
    ((pin_oe_out & port_mask) == port_mask) &&
    ((pin_out ^ port_e_data_latch) & port_mask) == 8'h00)
    else $error("port output pin not driving latch");

  in_off_a: assert property ((pin_oe_out & off_mask) == 8'h00)
    else $error("input pin driver not off");

  latch_wr_a: assert property (
    wr_data |=> port_e_data_latch == $past(reg_wdata_in) &&
                (pin_oe_out & ~$past(port_mask) & off_mask) == 8'h00)
    else $error("data write did not reach latch");

  out_read_a: assert property (
    s_rd_plain ##0 port_mask == 8'hff |=>
      reg_rdata_out == $past(port_e_data_latch))
    else $error("output read did not return latch");

  rmw_read_a: assert property (
    s_rd_rmw |=> reg_rdata_out == $past(port_e_data_latch))
    else $error("rmw read did not return latch");

  in_read_a: assert property (
    s_rd_plain ##0 port_e_direction == 8'h00 |=>
      reg_rdata_out == $past(level))
    else $error("input read did not return level");

  tmr_drive_a: assert property (
    ((pin_out ^ periph_val) & tmr_mask) == 8'h00 &&
    (pin_oe_out & tmr_mask) == tmr_mask)
    else $error("timer pin not driven by timer");

  per_read_a: assert property (
    s_rd_plain |=>
      ((reg_rdata_out ^ $past(level)) & $past(tmr_mask)) == 8'h00)
    else $error("timer pin read not pin level");

  reset_dir_a: assert property (disable iff (1'b0)
    $fell(rst_in) |-> port_e_direction == 8'h00 && pin_oe_out == 8'h00)
    else $error("reset left a direction bit set");

  hiz_force_a: assert property (
    hiz_force |-> pin_oe_out == 8'h00 && level == 8'h00 &&
                  !tmr_ext_clk_out)
    else $error("standby hi-z not forced");

  standby_keep_a: assert property (
    s_standby_quiet ##1 $stable(periph_oe) |-> $stable(pin_oe_out))
    else $error("standby without select changed drive");

  dir_rw_a: assert property (
    s_wr_dir_then_rd |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("direction write not read back");

  // lcd owned pins show their segment level
  lcd_drive_a: assert property (
    (pin_oe_out & lcd_mask) == lcd_mask &&
    ((pin_out ^ lcd_seg_in) & lcd_mask) == 8'h00)
    else $error("lcd pin not driven by segment");

  // read data falls back to zero outside its one cycle
  rd_idle_a: assert property (
    !reg_rd_in |=> reg_rdata_out == `SIO_RDATA_RST)
    else $error("read data stood past its cycle");

  // port and lcd drivers stay off until input control is set
  not_func_a: assert property (
    !lcd_port_input_control |-> (pin_oe_out & ~periph_oe) == 8'h00)
    else $error("port drove a pin before input control");

  // timer clock follows pin 7 unless standby cuts the input
  ext_clk_a: assert property (
    tmr_ext_clk_out == (pin_in[`SIO_EXTCLK_PIN] & ~hiz_force))
    else $error("timer clock not pin 7 level");

endmodule

`default_nettype wire

// *** verification/sio_far_model.sv ***
// outside world of the shared io port: pads and timer channel outputs
`timescale 1ns/1ps
`default_nettype none

module sio_far_model
  import sio_pkg::*;
(
  input  wire sio_pkg::sio_byte_t pin_out_in,    // port pad values
  input  wire sio_pkg::sio_byte_t pin_oe_in,     // port pad enables
  input  wire sio_pkg::sio_byte_t ext_in,        // outside level per pin
  input  wire logic [1:0]         tmr_cfg_in,    // timer enables, b:a
  input  wire logic [1:0]         tmr_val_in,    // timer levels, b:a
  output sio_pkg::sio_byte_t      pad_out,       // resolved pad levels
  output logic                    tmr_out_a_out, // timer output a
  output logic                    tmr_oe_a_out,  // timer enable a
  output logic                    tmr_out_b_out, // timer output b
  output logic                    tmr_oe_b_out   // timer enable b
);
  //////////////////////////////////////////////////////////////////////
  // pads: the port wins where it drives, the outside world elsewhere
  // outside always holds a level, so no input is left floating
  assign pad_out = (pin_oe_in & pin_out_in) |
                   (~pin_oe_in & ext_in);

  //////////////////////////////////////////////////////////////////////
  // timer stays disabled unless the bench asks, so port use is clean
  assign tmr_oe_a_out = tmr_cfg_in[0];
  assign tmr_oe_b_out = tmr_cfg_in[1];
  // disabled outputs show the inverse so a stale value never passes
  assign tmr_out_a_out = tmr_cfg_in[0] ? tmr_val_in[0] : ~tmr_val_in[0];
  assign tmr_out_b_out = tmr_cfg_in[1] ? tmr_val_in[1] : ~tmr_val_in[1];
endmodule
`default_nettype wire

// *** verification/sio_port_e_tb.sv ***
// self-checking bench for the eight-pin shared io port
`timescale 1ns/1ps
`default_nettype none
`include "sio_port_map.svh"

module sio_port_e_tb;
  import sio_pkg::*;

  typedef struct {
    sio_byte_t dir, data, ext, oe, out, rd, rmw;
  } sio_row_s;                  // one ordinary case and its results

  logic       clk_in;           // cpu clock
  logic       rst_in;           // cpu reset
  sio_addr_t  reg_addr_in;      // bus address
  sio_byte_t  reg_wdata_in;     // bus write data
  logic       reg_wr_in;        // write strobe
  logic       reg_rd_in;        // read strobe
  logic       reg_rmw_in;       // rmw qualifier
  sio_byte_t  reg_rdata_out;    // bus read data
  sio_byte_t  pin_in;           // resolved pads
  sio_byte_t  pin_out;          // pad values
  sio_byte_t  pin_oe_out;       // pad enables
  sio_byte_t  lcd_seg_in;       // segment levels
  sio_byte_t  ext;              // outside levels
  logic [1:0] tmr_cfg;          // timer enables
  logic [1:0] tmr_val;          // timer levels
  logic       tmr_out_a;        // timer a value
  logic       tmr_oe_a;         // timer a enable
  logic       tmr_out_b;        // timer b value
  logic       tmr_oe_b;         // timer b enable
  logic       tmr_ext_clk_out;  // gated pin 7
  logic       standby_stop_in;  // stop or watch
  int         err_count;        // mismatches
  int         tests_run;        // comparisons
  sio_byte_t  rd;               // last read value

  // dir, data, outside, oe, driven out, read, rmw read; bits 0 and 7 edges
  sio_row_s rows[4] = '{
    '{8'h00, 8'ha5, 8'h3c, 8'h00, 8'h00, 8'h3c, 8'ha5},
    '{8'hff, 8'h5a, 8'h00, 8'hff, 8'h5a, 8'h5a, 8'h5a},
    '{8'h0f, 8'hc3, 8'h96, 8'h0f, 8'h03, 8'h93, 8'hc3},
    '{8'h80, 8'h80, 8'h7f, 8'h80, 8'h80, 8'hff, 8'h80}};

  sio_port_e uut (.clk_in(clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rmw_in(reg_rmw_in),
    .reg_rdata_out(reg_rdata_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .lcd_seg_in(lcd_seg_in),
    .tmr_out_a_in(tmr_out_a), .tmr_oe_a_in(tmr_oe_a),
    .tmr_out_b_in(tmr_out_b), .tmr_oe_b_in(tmr_oe_b),
    .tmr_ext_clk_out(tmr_ext_clk_out), .standby_stop_in(standby_stop_in));

  sio_far_model far (.pin_out_in(pin_out), .pin_oe_in(pin_oe_out),
    .ext_in(ext), .tmr_cfg_in(tmr_cfg), .tmr_val_in(tmr_val),
    .pad_out(pin_in), .tmr_out_a_out(tmr_out_a), .tmr_oe_a_out(tmr_oe_a),
    .tmr_out_b_out(tmr_out_b), .tmr_oe_b_out(tmr_oe_b));

  //////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial begin
    clk_in = 1'h0;
    forever #2 clk_in = ~clk_in;
  end

  // one-cycle write, then an idle cycle so strobes never collide
  task automatic wr(input sio_addr_t a, input sio_byte_t d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'h1;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
    @(posedge clk_in);
  endtask

  // one-cycle read; data only stands in the following cycle
  task automatic rdr(input sio_addr_t a, input logic rmw,
                     output sio_byte_t v);
    reg_addr_in <= a;
    reg_rmw_in <= rmw;
    reg_rd_in <= 1'h1;
    @(posedge clk_in);
    reg_rd_in <= 1'h0;
    reg_rmw_in <= 1'h0;
    #1 v = reg_rdata_out;
    @(posedge clk_in);
  endtask

  // compare and count
  task automatic check(input string name, input sio_byte_t seen,
                       input sio_byte_t exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    finish_test();
  end

  // main sequence
  initial begin
    err_count = 0;
    tests_run = 0;
    rst_in = 1'h1;
    reg_addr_in = 4'h0;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'h0;
    reg_rd_in = 1'h0;
    reg_rmw_in = 1'h0;
    lcd_seg_in = 8'h00;
    ext = 8'h00;
    tmr_cfg = 2'h0;
    tmr_val = 2'h0;
    standby_stop_in = 1'h0;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'h0;
    @(posedge clk_in);
    check("oe_reset", pin_oe_out, 8'h00);
    rdr(`SIO_OFF_DIR, 1'h0, rd);
    check("dir_reset", rd, `SIO_DIR_RST);
    wr(`SIO_OFF_CTRL, 8'h01);
    // ordinary cases from the table
    foreach (rows[i]) begin
      wr(`SIO_OFF_DIR, rows[i].dir);
      wr(`SIO_OFF_DATA, rows[i].data);
      ext <= rows[i].ext;
      rdr(`SIO_OFF_DATA, 1'h0, rd);
      check("data_read", rd, rows[i].rd);
      rdr(`SIO_OFF_DATA, 1'h1, rd);
      check("rmw_read", rd, rows[i].rmw);
      #1 check("pad_enable", pin_oe_out, rows[i].oe);
      check("pad_value", pin_out & pin_oe_out, rows[i].out);
      @(posedge clk_in);
    end
    // timer takes pins 6 and 5, pin 7 feeds its clock
    wr(`SIO_OFF_DIR, 8'h00);
    wr(`SIO_OFF_DATA, 8'h00);
    tmr_cfg <= 2'h3;
    tmr_val <= 2'h1;
    ext <= 8'h80;
    rdr(`SIO_OFF_DATA, 1'h0, rd);
    check("timer_read", rd, 8'hc0);
    rdr(`SIO_OFF_DATA, 1'h1, rd);
    check("timer_rmw", rd, 8'h00);
    #1 check("timer_oe", pin_oe_out, 8'h60);
    check("timer_out", pin_out & 8'h60, 8'h40);
    check("ext_clock", {7'h0, tmr_ext_clk_out}, 8'h01);
    @(posedge clk_in);
    tmr_cfg <= 2'h0;
    // lcd segments on pins 0 and 7
    lcd_seg_in <= 8'h80;
    wr(`SIO_OFF_SEGSEL, 8'h81);
    #1 check("lcd_oe", pin_oe_out, 8'h81);
    check("lcd_out", pin_out & 8'h81, 8'h80);
    @(posedge clk_in);
    wr(`SIO_OFF_SEGSEL, 8'h00);
    // standby with and without forced hi-z
    wr(`SIO_OFF_DATA, 8'h3c);
    wr(`SIO_OFF_DIR, 8'hff);
    wr(`SIO_OFF_CTRL, 8'h03);
    ext <= 8'hff;
    standby_stop_in <= 1'h1;
    @(posedge clk_in);
    #1 check("hiz_oe", pin_oe_out, 8'h00);
    check("hiz_clock", {7'h0, tmr_ext_clk_out}, 8'h00);
    @(posedge clk_in);
    rdr(`SIO_OFF_LEVEL, 1'h0, rd);
    check("hiz_level", rd, 8'h00);
    wr(`SIO_OFF_CTRL, 8'h01);
    #1 check("keep_oe", pin_oe_out, 8'hff);
    check("keep_out", pin_out, 8'h3c);
    @(posedge clk_in);
    standby_stop_in <= 1'h0;
    // register access, reserved bits and an unmapped place
    wr(`SIO_OFF_CTRL, 8'hff);
    rdr(`SIO_OFF_CTRL, 1'h0, rd);
    check("ctrl_read", rd, 8'hff & `SIO_CTRL_MASK);
    rdr(`SIO_OFF_DIR, 1'h0, rd);
    check("dir_read", rd, 8'hff);
    rdr(4'h5, 1'h0, rd);
    check("unmapped", rd, `SIO_UNMAPPED_RD);
    // back to back: direction write, read at once, data then clears
    reg_addr_in <= `SIO_OFF_DIR;
    reg_wdata_in <= 8'h5a;
    reg_wr_in <= 1'h1;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
    reg_rd_in <= 1'h1;
    @(posedge clk_in);
    reg_rd_in <= 1'h0;
    #1 check("dir_b2b", reg_rdata_out, 8'h5a);
    @(posedge clk_in);
    #1 check("rd_clear", reg_rdata_out, `SIO_RDATA_RST);
    // second reset in mid-run
    rst_in <= 1'h1;
    @(posedge clk_in);
    #1 check("oe_rerst", pin_oe_out, 8'h00);
    @(posedge clk_in);
    rst_in <= 1'h0;
    @(posedge clk_in);
    rdr(`SIO_OFF_DIR, 1'h0, rd);
    check("dir_rerst", rd, 8'h00);
    // direction set but input control still clear: pins stay hi-z
    wr(`SIO_OFF_DIR, 8'hff);
    #1 check("not_func", pin_oe_out, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
